// File: core/prot_status_pkg.sv
// constants for the eeprom protection and status block
// assumes a single 40 MHz system clock; spi pins arrive asynchronously
package prot_status_pkg;
  localparam logic [7:0] CMD_SET_LATCH    = 8'h06;
  localparam logic [7:0] CMD_CLEAR_LATCH  = 8'h04;
  localparam logic [7:0] CMD_STATUS_READ  = 8'h05;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_WRITE_MASK   = 8'hf7;
  localparam logic [7:0] CMD_WRITE_BASE   = 8'h02;
  localparam int         BUSY_BIT         = 0;
  localparam int         LATCH_BIT        = 1;
  localparam int         GUARD_LO_BIT     = 2;
  localparam int         GUARD_HI_BIT     = 3;
  localparam int         ADDR_W           = 9;
  localparam int         ADDR_HI_BIT      = 3;
  localparam logic [8:0] GUARD_QUARTER    = 9'h180;
  localparam logic [8:0] GUARD_HALF       = 9'h100;
  localparam logic [8:0] GUARD_ALL        = 9'h000;
  localparam logic [3:0] UPPER_ZERO       = 4'h0;
  localparam int         WRITE_TIME_NS    = 5000000;
  localparam int         CLK_PERIOD_NS    = 25;
  localparam int         WRITE_CYCLES     = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [2:0] BIT_LAST         = 3'h7;
  localparam logic [1:0] GUARD_RESET      = 2'h0;
  localparam logic [3:0] PIN_IDLE         = 4'h9;
endpackage : prot_status_pkg

// File: core/prot_status.sv
// protection and status logic of a 512-byte spi serial eeprom
// assumes spi pins (cs, sck, si, wp) are asynchronous to ref_clk_in and much slower
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Summary of operation
// - status read is answered any time, even during an internal write.
// - status bit0 busy, bit1 latch, bits 3:2 guard bits, upper bits free.
// - busy reads 1 during internal write; status writes cannot change it.
// - latch flag shows write enable latch; status write cannot change it.
// - set and clear latch commands work regardless of status protection.
// - guard bits change only by status write and are kept nonvolatile.
// - guard code 00 none, 01 180-1ff, 10 100-1ff, 11 whole array.
// - write enable latch is clear after power-up.
// - latch clears when a byte, page or status write completes.
// - internal write starts only on a cs rise right after a whole byte.
// - array access during an internal write is ignored; programming continues.
// - latch held clear while the write-protect pin is low.
// - powers up idle with so tri-stated; active only after cs falls.
// - wp low or latch clear blocks all writes; else only guarded ones and those during busy are blocked.
// - command 06 sets the latch, command 04 clears it.
// - command 05 reads status, command 01 writes status.
// - commands and status data shift most significant bit first.
// - a wp fall does not abort an internal write already begun.
module prot_status #(
  parameter int WRITE_CYCLES = prot_status_pkg::WRITE_CYCLES
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       cs_n_in,
  input  wire logic       sck_in,
  input  wire logic       si_in,
  input  wire logic       wp_n_in,
  output logic            so_out,
  output logic            so_oe_out,
  output logic            write_busy_flag_out,
  output logic            write_latch_flag_out,
  output logic [1:0]      block_guard_out,
  output logic            array_write_start_out,
  output logic [8:0]      array_addr_out
);

  typedef enum logic [1:0] {
    ST_CMD  = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b11,
    ST_SKIP = 2'b10
  } phase_type;

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; only the second stage is read
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic       sck_d_r;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sync1_r <= prot_status_pkg::PIN_IDLE;
      sync2_r <= prot_status_pkg::PIN_IDLE;
      sck_d_r <= 1'b0;
    end else begin
      sync1_r <= {cs_n_in, sck_in, si_in, wp_n_in};
      sync2_r <= sync1_r;
      sck_d_r <= sync2_r[2];
    end
  end
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic wp_n_s;
  assign cs_n_s = sync2_r[3];
  assign sck_s  = sync2_r[2];
  assign si_s   = sync2_r[1];
  assign wp_n_s = sync2_r[0];
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_n_d_r;
  assign sck_rise = sck_s & ~sck_d_r & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_d_r & ~cs_n_s;
  assign cs_rise  = cs_n_s & ~cs_n_d_r;

  ////////////////////////////////////////////////////////////////////////
  // serial front end, status byte and protection state
  phase_type  phase_r, phase_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [8:0] addr_r, addr_nxt;
  logic       byte_end_r, byte_end_nxt;
  logic       got_data_r, got_data_nxt;
  logic       latch_r, latch_nxt;
  logic [1:0] guard_r, guard_nxt;
  logic [1:0] guard_new_r, guard_new_nxt;
  logic       busy_r, busy_nxt;
  logic       st_write_r, st_write_nxt;
  logic [31:0] timer_r, timer_nxt;
  logic       so_r, so_nxt;
  logic       so_oe_r, so_oe_nxt;
  logic       start_r, start_nxt;
  logic [7:0] status_byte;
  logic       is_array_write;
  logic       guarded;
  logic       write_ok;

  // unused upper bits read as zero
  assign status_byte = {prot_status_pkg::UPPER_ZERO, guard_r, latch_r, busy_r};
  assign is_array_write = (cmd_r & prot_status_pkg::CMD_WRITE_MASK) == prot_status_pkg::CMD_WRITE_BASE;

  always_comb begin
    case (guard_r)
      2'b01:   guarded = addr_r >= prot_status_pkg::GUARD_QUARTER;
      2'b10:   guarded = addr_r >= prot_status_pkg::GUARD_HALF;
      2'b11:   guarded = addr_r >= prot_status_pkg::GUARD_ALL;
      default: guarded = 1'b0;
    endcase
  end
  // wp low or latch clear protects everything
  assign write_ok = wp_n_s & latch_r & ~busy_r;

  always_comb begin
    phase_nxt     = phase_r;
    bit_nxt       = bit_r;
    shift_nxt     = shift_r;
    cmd_nxt       = cmd_r;
    addr_nxt      = addr_r;
    byte_end_nxt  = byte_end_r;
    got_data_nxt  = got_data_r;
    latch_nxt     = latch_r;
    guard_nxt     = guard_r;
    guard_new_nxt = guard_new_r;
    busy_nxt      = busy_r;
    st_write_nxt  = st_write_r;
    timer_nxt     = timer_r;
    so_nxt        = so_r;
    so_oe_nxt     = so_oe_r;
    start_nxt     = 1'b0;
    if (cs_n_s) begin
      phase_nxt    = ST_CMD;
      bit_nxt      = 3'h0;
      byte_end_nxt = 1'b0;
      got_data_nxt = 1'b0;
      so_oe_nxt    = 1'b0;
    end
    if (sck_rise) begin
      shift_nxt    = {shift_r[6:0], si_s};
      bit_nxt      = bit_r + 3'h1;
      byte_end_nxt = (bit_r == prot_status_pkg::BIT_LAST);
      if (bit_r == prot_status_pkg::BIT_LAST) begin
        case (phase_r)
          ST_CMD: begin
            cmd_nxt = {shift_r[6:0], si_s};
            if ((({shift_r[6:0], si_s}) & prot_status_pkg::CMD_WRITE_MASK) == prot_status_pkg::CMD_WRITE_BASE) begin
              phase_nxt = ST_ADDR;
              addr_nxt  = {shift_r[prot_status_pkg::ADDR_HI_BIT - 1], 8'h00};
            end else if (({shift_r[6:0], si_s}) == prot_status_pkg::CMD_STATUS_WRITE) begin
              phase_nxt = ST_DATA;
            end else begin
              phase_nxt = ST_SKIP;
            end
          end
          ST_ADDR: begin
            addr_nxt  = {addr_r[8], shift_r[6:0], si_s};
            phase_nxt = ST_DATA;
          end
          ST_DATA: begin
            got_data_nxt  = 1'b1;
            guard_new_nxt = {shift_r[prot_status_pkg::GUARD_HI_BIT - 1],
                             shift_r[prot_status_pkg::GUARD_LO_BIT - 1]};
          end
          default: phase_nxt = ST_SKIP;
        endcase
      end else begin
        byte_end_nxt = 1'b0;
      end
    end
    // status read: present msb first, update after each falling edge
    if (cmd_r == prot_status_pkg::CMD_STATUS_READ && phase_r == ST_SKIP && sck_fall) begin
      so_oe_nxt = 1'b1;
      so_nxt    = status_byte[~bit_r];
    end
    if (cs_rise && byte_end_r) begin
      if (phase_r == ST_SKIP && cmd_r == prot_status_pkg::CMD_SET_LATCH) begin
        latch_nxt = wp_n_s;
      end
      if (phase_r == ST_SKIP && cmd_r == prot_status_pkg::CMD_CLEAR_LATCH) begin
        latch_nxt = 1'b0;
      end
      if (phase_r == ST_DATA && got_data_r && write_ok) begin
        if (cmd_r == prot_status_pkg::CMD_STATUS_WRITE) begin
          busy_nxt     = 1'b1;
          st_write_nxt = 1'b1;
          timer_nxt    = 32'(WRITE_CYCLES);
        end else if (is_array_write && !guarded) begin
          busy_nxt  = 1'b1;
          start_nxt = 1'b1;
          timer_nxt = 32'(WRITE_CYCLES);
        end
      end
    end
    // an internal write runs to the end whatever wp does
    if (busy_r) begin
      if (timer_r <= 32'd1) begin
        busy_nxt     = 1'b0;
        latch_nxt    = 1'b0;
        st_write_nxt = 1'b0;
        if (st_write_r) begin
          guard_nxt = guard_new_r;
        end
      end else begin
        timer_nxt = timer_r - 32'd1;
      end
    end
    if (!wp_n_s) begin
      latch_nxt = 1'b0;
    end
  end

  // guard bits model nonvolatile cells; reset does not clear them here
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      phase_r     <= ST_CMD;
      bit_r       <= 3'h0;
      shift_r     <= 8'h00;
      cmd_r       <= 8'h00;
      addr_r      <= 9'h000;
      byte_end_r  <= 1'b0;
      got_data_r  <= 1'b0;
      latch_r     <= 1'b0;
      busy_r      <= 1'b0;
      st_write_r  <= 1'b0;
      timer_r     <= 32'h0;
      so_r        <= 1'b0;
      so_oe_r     <= 1'b0;
      start_r     <= 1'b0;
      guard_new_r <= prot_status_pkg::GUARD_RESET;
      cs_n_d_r    <= 1'b1;
    end else begin
      phase_r     <= phase_nxt;
      bit_r       <= bit_nxt;
      shift_r     <= shift_nxt;
      cmd_r       <= cmd_nxt;
      addr_r      <= addr_nxt;
      byte_end_r  <= byte_end_nxt;
      got_data_r  <= got_data_nxt;
      latch_r     <= latch_nxt;
      busy_r      <= busy_nxt;
      st_write_r  <= st_write_nxt;
      timer_r     <= timer_nxt;
      so_r        <= so_nxt;
      so_oe_r     <= so_oe_nxt;
      start_r     <= start_nxt;
      guard_new_r <= guard_new_nxt;
      cs_n_d_r    <= cs_n_s;
    end
  end

  logic guard_init_r = 1'b0; // configuration state: only the first reset loads the cells
  always_ff @(posedge ref_clk_in) begin
    if (rst_in && !guard_init_r) begin
      guard_r      <= prot_status_pkg::GUARD_RESET;
      guard_init_r <= 1'b1;
    end else begin
      guard_r      <= guard_nxt;
      guard_init_r <= 1'b1;
    end
  end

  assign so_out                = so_r;
  assign so_oe_out             = so_oe_r;
  assign write_busy_flag_out   = busy_r;
  assign write_latch_flag_out  = latch_r;
  assign block_guard_out       = guard_r;
  assign array_write_start_out = start_r;
  assign array_addr_out        = addr_r;

  ////////////////////////////////////////////////////////////////////////
  AST_WP_CLEARS_LATCH: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !wp_n_s |=> !latch_r) else $error("latch set while wp low");
  AST_LATCH_NEEDS_WP: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(latch_r) |-> $past(wp_n_s) && $past(cs_rise)) else $error("latch set without cause");
  AST_BUSY_END_CLEARS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $fell(busy_r) |-> !latch_r) else $error("latch survived write");
  AST_BUSY_ON_CS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(busy_r) |-> $past(cs_rise) && $past(byte_end_r)) else $error("write began off cs rise");
  AST_NO_WRITE_PROT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(busy_r) |-> $past(latch_r) && $past(wp_n_s)) else $error("protected write started");
  AST_GUARD_STABLE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !st_write_r |=> $stable(guard_r)) else $error("guard changed without status write");
  AST_START_UNGUARDED: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    start_r |-> !guarded && busy_r) else $error("guarded address written");
  AST_SO_IDLE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cs_n_s |=> !so_oe_r) else $error("so driven while deselected");
  AST_BUSY_HOLDS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(busy_r) |-> busy_r [*8]) else $error("write cut short");

endmodule : prot_status

// File: dv/spi_host.sv
// host spi master model that drives the eeprom protection block's serial pins
// assumes the bench calls frame(); sck stands low and cs high between frames
`timescale 1ns/1ps
module spi_host (
  input  wire logic ref_clk_in,
  input  wire logic so_in,
  input  wire logic so_oe_in,
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      si_out
);
  // ten ref clocks per sck half stays well clear of the pin synchroniser
  localparam int HALF = 10;
  logic so_last = 1'b0;
  // a released so line shows the inverse of its last value, never a stale copy
  wire  so_line = so_oe_in ? so_in : ~so_last;
  initial begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    si_out   = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // last_bits below 8 cuts the final byte short, which the device must refuse
  task automatic frame(input logic [7:0] q[$], input int last_bits, output logic [7:0] rx);
    int n;
    @(posedge ref_clk_in);
    cs_n_out <= 1'b0;
    repeat (HALF) @(posedge ref_clk_in);
    foreach (q[k]) begin
      n = (k == q.size() - 1) ? last_bits : 8;
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
        si_out <= q[k][i];
        repeat (HALF) @(posedge ref_clk_in);
        sck_out <= 1'b1;
        rx[i] = so_line;
        so_last = so_line;
        repeat (HALF) @(posedge ref_clk_in);
        sck_out <= 1'b0;
      end
    end
    repeat (HALF) @(posedge ref_clk_in);
    cs_n_out <= 1'b1;
    repeat (2 * HALF) @(posedge ref_clk_in);
  endtask : frame
endmodule : spi_host

// File: dv/testbench.sv
// self-checking bench for the eeprom protection and status block
// assumes spi_host drives the serial pins; the write time is cut to WCYC clocks
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
  localparam int WCYC = 1000;
  logic       ref_clk_in = 1'b0;
  logic       rst_in     = 1'b1;
  logic       wp_n_in    = 1'b1;
  wire        cs_n, sck, si, so, so_oe, busy, latch, start;
  wire  [1:0] guard;
  wire  [8:0] addr;
  logic [7:0] rx;
  logic [8:0] last_addr  = 9'h000;
  int         n_start    = 0;
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         cycles     = 0;
  always #12.5 ref_clk_in = ~ref_clk_in;
  prot_status #(.WRITE_CYCLES(WCYC)) dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .cs_n_in(cs_n),
    .sck_in(sck), .si_in(si), .wp_n_in(wp_n_in), .so_out(so), .so_oe_out(so_oe), .write_busy_flag_out(busy),
    .write_latch_flag_out(latch), .block_guard_out(guard), .array_write_start_out(start), .array_addr_out(addr));
  spi_host host_u (.ref_clk_in(ref_clk_in), .so_in(so), .so_oe_in(so_oe), .cs_n_out(cs_n), .sck_out(sck),
    .si_out(si));
  // the ceiling is about two and a half times the expected run length
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (start === 1'b1) begin
      n_start   <= n_start + 1;
      last_addr <= addr;
    end
    if (cycles == 95000) begin
      n_mismatch++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic cmd(input logic [7:0] c);
    host_u.frame('{c}, 8, rx);
  endtask : cmd
  task automatic wait_idle();
    for (int i = 0; i < 2 * WCYC && busy !== 1'b0; i++) @(posedge ref_clk_in);
    `CHK(busy, 1'b0)
  endtask : wait_idle
  task automatic write(input logic [8:0] a, input int bits);
    cmd(prot_status_pkg::CMD_SET_LATCH);
    host_u.frame('{prot_status_pkg::CMD_WRITE_BASE | {4'h0, a[8], 3'h0}, a[7:0], 8'h5a}, bits, rx);
  endtask : write
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_power_on();
    `CHK({so_oe, busy, latch, guard}, 5'h00)
  endtask : t_power_on
  task automatic t_latch();
    cmd(prot_status_pkg::CMD_SET_LATCH);
    `CHK(latch, 1'b1)
    host_u.frame('{prot_status_pkg::CMD_STATUS_READ, 8'h00}, 8, rx);
    `CHK(rx, 8'h02)
    cmd(prot_status_pkg::CMD_CLEAR_LATCH);
    `CHK(latch, 1'b0)
  endtask : t_latch
  // every guard code against both sides of each protected boundary
  task automatic t_guard(input logic [1:0] code);
    logic [8:0] a[6] = '{9'h000, 9'h0ff, 9'h100, 9'h17f, 9'h180, 9'h1ff};
    logic       hit;
    int         n0;
    cmd(prot_status_pkg::CMD_SET_LATCH);
    host_u.frame('{prot_status_pkg::CMD_STATUS_WRITE, {4'hf, code, 2'h3}}, 8, rx);
    host_u.frame('{prot_status_pkg::CMD_STATUS_READ, 8'h00}, 8, rx);
    `CHK(rx, {4'h0, code - 2'h1, 2'h3})
    wait_idle();
    `CHK({guard, latch}, {code, 1'b0})
    foreach (a[i]) begin
      n0 = n_start;
      hit = code == 2'h3 || (code == 2'h2 && a[i] >= 9'h100) || (code == 2'h1 && a[i] >= 9'h180);
      write(a[i], 8);
      `CHK(n_start - n0, hit ? 0 : 1)
      if (!hit) `CHK(last_addr, a[i])
      wait_idle();
      `CHK(latch, hit)
    end
  endtask : t_guard
  task automatic t_busy_wp();
    int n0;
    n0 = n_start;
    write(9'h010, 8);
    host_u.frame('{prot_status_pkg::CMD_WRITE_BASE, 8'h11, 8'h33}, 8, rx);
    `CHK(n_start - n0, 1)
    wp_n_in <= 1'b0;
    repeat (20) @(posedge ref_clk_in);
    `CHK({busy, latch}, 2'h2)
    wait_idle();
    cmd(prot_status_pkg::CMD_SET_LATCH);
    `CHK(latch, 1'b0)
    n0 = n_start;
    write(9'h020, 8);
    host_u.frame('{prot_status_pkg::CMD_STATUS_WRITE, 8'h0c}, 8, rx);
    `CHK(n_start - n0, 0)
    `CHK({busy, guard}, 3'h0)
    wp_n_in <= 1'b1;
    write(9'h030, 4);
    `CHK(n_start - n0, 0)
    `CHK(busy, 1'b0)
  endtask : t_busy_wp
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    t_power_on();
    t_latch();
    for (int c = 1; c < 5; c++) t_guard(c[1:0]);
    t_busy_wp();
    finish_test();
  end
endmodule : testbench
